// file: verilog/vectored_interrupt_arbiter_regs.svh
`ifndef VECTORED_INTERRUPT_ARBITER_REGS_SVH
`define VECTORED_INTERRUPT_ARBITER_REGS_SVH
// register offsets (byte addresses on the plain port)
`define OFS_FLAG_A          8'h00
`define OFS_FLAG_B          8'h01
`define OFS_FLAG_C          8'h02
`define OFS_MASK_A          8'h04
`define OFS_MASK_B          8'h05
`define OFS_MASK_C          8'h06
`define OFS_LEVEL_A         8'h08
`define OFS_LEVEL_B         8'h09
`define OFS_LEVEL_C         8'h0a
`define OFS_CTRL            8'h0c
`define OFS_STATUS          8'h0d
`define OFS_IRQ_STAT        8'h0e
`define OFS_IRQ_MASK        8'h0f
// control bit positions
`define CTRL_ACCEPT_BIT     0
`define CTRL_LVD_ACTION_BIT 1
`define CTRL_CARRIER_BIT    2
// reset values
`define MASK_RESET          8'hff
`define LEVEL_RESET         8'hff
`define CTRL_RESET          8'h00
// vector addresses
`define VEC_RESET           16'h0000
`define VEC_LVD             16'h0004
`define VEC_PIN0            16'h0006
`define VEC_SER_ERR         16'h0012
`define VEC_SER_RX          16'h0014
`define VEC_SER_TX          16'h0016
`define VEC_HTB             16'h001a
`define VEC_HTA             16'h001c
`define VEC_ETA             16'h001e
`define VEC_WT0             16'h0020
`define VEC_WT1             16'h0022
`define VEC_ETB             16'h002a
`define VEC_BREAK           16'h003e
`define NUM_SRC             18
`endif

// file: verilog/vectored_interrupt_arbiter_pkg.sv
package vectored_interrupt_arbiter_pkg;
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LOW  = 2'b01,
    SVC_HIGH = 2'b10,
    SVC_NEST = 2'b11
  } svc_state_t;
  typedef logic [17:0] src_vec_t;
endpackage

// file: verilog/default_order_picker.sv
`timescale 1ns/1ns
// lowest index wins: index equals default priority
module default_order_picker
  import vectored_interrupt_arbiter_pkg::*;
(
  input  wire src_vec_t   req_i,
  output logic            any_o,
  output logic [4:0]      idx_o
);
  always_comb begin
    any_o = 1'b0;
    idx_o = 5'h00;
    for (int i = 17; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = 5'(i);
      end
    end
  end
endmodule

// file: verilog/vectored_interrupt_arbiter.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`include "vectored_interrupt_arbiter_regs.svh"
// What this block does
// - level group flags in three 8-bit registers split sources into high or low group
// - high request may interrupt low service already running, nesting
// - equal-group simultaneous requests resolved by fixed default order
// - default order ranks sources 0 (low voltage) to 17 (second key)
// - any pending unmasked request raises standby release for stop and halt
// - software break vectors to 003eh even with acceptance disabled
// - software break ignores level groups and in-service state
// - six pin edge requests vector 0006h to 0010h in pin order
// - serial error, receive done, transmit done vector 0012h, 0014h, 0016h
// - high timer b, high timer a, event timer a match vector 001ah, 001ch, 001eh
// - wide timer channels at 0020h, 0022h fire on match or capture edge
// - low voltage raises interrupt at 0004h only when action bit is 0
// - eight external and ten internal maskable request inputs
// - carrier mode: event timer b interrupt raised on carrier match signal
// - acknowledge clears the accepted source's pending flag
// - reset sets the three source mask registers to all ones
module vectored_interrupt_arbiter
  import vectored_interrupt_arbiter_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // external requests, asynchronous pins
  input  wire logic [5:0]  pin_edge_irq_i,
  input  wire logic [1:0]  key_input_irq_i,
  // internal requests, core clock pulses
  input  wire logic        low_voltage_irq_i,
  input  wire logic        serial_rx_error_irq_i,
  input  wire logic        serial_rx_done_irq_i,
  input  wire logic        serial_tx_done_irq_i,
  input  wire logic        high_timer_b_match_irq_i,
  input  wire logic        high_timer_a_match_irq_i,
  input  wire logic        event_timer_a_match_irq_i,
  input  wire logic        wide_timer_ch0_irq_i,
  input  wire logic        wide_timer_ch1_irq_i,
  input  wire logic        event_timer_b_match_irq_i,
  input  wire logic        carrier_match_signal_i,
  // core handshake
  input  wire logic        software_break_instruction_i,
  input  wire logic        ack_i,
  input  wire logic        reti_i,
  output logic             int_req_o,
  output logic      [15:0] vector_o,
  output logic             standby_release_o,
  output logic             lvd_reset_o,
  output logic             irq_o
);
  logic [5:0]  pin_s1_q;
  logic [5:0]  pin_s2_q;
  logic [5:0]  pin_s3_q;
  logic [1:0]  key_s1_q;
  logic [1:0]  key_s2_q;
  logic [1:0]  key_s3_q;
  src_vec_t    flag_q;
  src_vec_t    mask_q;
  src_vec_t    level_q;
  logic [7:0]  ctrl_q;
  logic        brk_q;
  svc_state_t  svc_q;
  logic [4:0]  sel_q;
  logic        sel_brk_q;
  logic [1:0]  ev_stat_q;
  logic [1:0]  ev_mask_q;
  src_vec_t    raw;
  src_vec_t    ready_hi;
  src_vec_t    ready_lo;
  src_vec_t    ack_clr;
  logic        any_hi;
  logic        any_lo;
  logic [4:0]  idx_hi;
  logic [4:0]  idx_lo;
  logic        accept_en;
  logic        allow_lo;
  logic        allow_hi;
  logic        win_hi;
  logic        win_lo;
  logic        etb_src;
  logic        wr_flag;
  logic [15:0] vec_d;
  logic        ev_ack;
  logic        ev_brk;

  assign accept_en = ctrl_q[`CTRL_ACCEPT_BIT];

  // pins are asynchronous: two stages, then a third for the rising edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      pin_s3_q <= 6'h00;
      key_s1_q <= 2'h0;
      key_s2_q <= 2'h0;
      key_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= pin_edge_irq_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      key_s1_q <= key_input_irq_i;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end

  // carrier mode swaps event timer b's own match for the carrier signal
  assign etb_src = ctrl_q[`CTRL_CARRIER_BIT] ? carrier_match_signal_i :
                   event_timer_b_match_irq_i;

  // source bit = default priority index
  always_comb begin
    raw        = '0;
    raw[0]     = low_voltage_irq_i & ~ctrl_q[`CTRL_LVD_ACTION_BIT];
    raw[6:1]   = pin_s2_q & ~pin_s3_q;
    raw[7]     = serial_rx_error_irq_i;
    raw[8]     = serial_rx_done_irq_i;
    raw[9]     = serial_tx_done_irq_i;
    raw[10]    = high_timer_b_match_irq_i;
    raw[11]    = high_timer_a_match_irq_i;
    raw[12]    = event_timer_a_match_irq_i;
    raw[13]    = wide_timer_ch0_irq_i;
    raw[14]    = wide_timer_ch1_irq_i;
    raw[15]    = etb_src;
    raw[17:16] = key_s2_q & ~key_s3_q;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvd_reset_o <= 1'b0;
    end else begin
      lvd_reset_o <= low_voltage_irq_i & ctrl_q[`CTRL_LVD_ACTION_BIT];
    end
  end

  // priority qualification
  assign ready_hi = flag_q & ~mask_q & ~level_q;
  assign ready_lo = flag_q & ~mask_q & level_q;
  assign allow_hi = accept_en & (svc_q == SVC_IDLE || svc_q == SVC_LOW);
  assign allow_lo = accept_en & (svc_q == SVC_IDLE);

  default_order_picker u_pick_hi (
    .req_i (ready_hi),
    .any_o (any_hi),
    .idx_o (idx_hi)
  );

  default_order_picker u_pick_lo (
    .req_i (ready_lo),
    .any_o (any_lo),
    .idx_o (idx_lo)
  );

  assign win_hi = any_hi & allow_hi;
  assign win_lo = ~win_hi & any_lo & allow_lo;

  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    logic [15:0] v;
    v = `VEC_LVD;
    if (idx >= 5'd1 && idx <= 5'd6) begin
      v = `VEC_PIN0 + 16'({idx - 5'd1, 1'b0});
    end else if (idx == 5'd7) begin
      v = `VEC_SER_ERR;
    end else if (idx == 5'd8) begin
      v = `VEC_SER_RX;
    end else if (idx == 5'd9) begin
      v = `VEC_SER_TX;
    end else if (idx == 5'd10) begin
      v = `VEC_HTB;
    end else if (idx == 5'd11) begin
      v = `VEC_HTA;
    end else if (idx == 5'd12) begin
      v = `VEC_ETA;
    end else if (idx == 5'd13) begin
      v = `VEC_WT0;
    end else if (idx == 5'd14) begin
      v = `VEC_WT1;
    end else if (idx == 5'd15) begin
      v = `VEC_ETB;
    end else if (idx >= 5'd16) begin
      v = `VEC_ETB + 16'({idx - 5'd15, 1'b0});
    end
    return v;
  endfunction

  // break outranks everything and skips the level logic
  always_comb begin
    vec_d = `VEC_RESET;
    if (brk_q) begin
      vec_d = `VEC_BREAK;
    end else if (win_hi) begin
      vec_d = vec_of(idx_hi);
    end else if (win_lo) begin
      vec_d = vec_of(idx_lo);
    end
  end

  // request held until the core acknowledges; vector may change while waiting
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_req_o <= 1'b0;
      vector_o  <= `VEC_RESET;
      sel_q     <= 5'h00;
      sel_brk_q <= 1'b0;
    end else if (int_req_o && ack_i) begin
      int_req_o <= 1'b0;
    end else begin
      int_req_o <= brk_q | win_hi | win_lo;
      vector_o  <= vec_d;
      sel_brk_q <= brk_q;
      sel_q     <= win_hi ? idx_hi : idx_lo;
    end
  end

  assign ev_ack = int_req_o & ack_i;
  assign ev_brk = ev_ack & sel_brk_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk_q <= 1'b0;
    end else if (software_break_instruction_i) begin
      brk_q <= 1'b1;
    end else if (ev_brk) begin
      brk_q <= 1'b0;
    end
  end

  // two-level service tracking; break does not touch it
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      svc_q <= SVC_IDLE;
    end else begin
      case (svc_q)
        SVC_IDLE: begin
          if (ev_ack && !sel_brk_q) begin
            svc_q <= level_q[sel_q] ? SVC_LOW : SVC_HIGH;
          end
        end
        SVC_LOW: begin
          if (ev_ack && !sel_brk_q && !level_q[sel_q]) begin
            svc_q <= SVC_NEST;
          end else if (reti_i) begin
            svc_q <= SVC_IDLE;
          end
        end
        SVC_NEST: begin
          if (reti_i) begin
            svc_q <= SVC_LOW;
          end
        end
        default: begin
          if (reti_i) begin
            svc_q <= SVC_IDLE;
          end
        end
      endcase
    end
  end

  assign wr_flag = wr_i && addr_i >= `OFS_FLAG_A && addr_i <= `OFS_FLAG_C;

  // hardware set wins over software write in the same cycle
  always_comb begin
    ack_clr = '0;
    if (ev_ack && !sel_brk_q) begin
      ack_clr[sel_q] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= '0;
    end else if (wr_flag) begin
      if (addr_i == `OFS_FLAG_A) begin
        flag_q <= {flag_q[17:8], wdata_i} & ~ack_clr | raw;
      end else if (addr_i == `OFS_FLAG_B) begin
        flag_q <= {flag_q[17:16], wdata_i, flag_q[7:0]} & ~ack_clr | raw;
      end else begin
        flag_q <= {wdata_i[1:0], flag_q[15:0]} & ~ack_clr | raw;
      end
    end else begin
      flag_q <= flag_q & ~ack_clr | raw;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q  <= 18'({`MASK_RESET, `MASK_RESET, `MASK_RESET} >> 6);
      level_q <= 18'({`LEVEL_RESET, `LEVEL_RESET, `LEVEL_RESET} >> 6);
      ctrl_q  <= `CTRL_RESET;
      ev_mask_q <= 2'h0;
    end else if (wr_i) begin
      if (addr_i == `OFS_MASK_A) begin
        mask_q[7:0] <= wdata_i;
      end else if (addr_i == `OFS_MASK_B) begin
        mask_q[15:8] <= wdata_i;
      end else if (addr_i == `OFS_MASK_C) begin
        mask_q[17:16] <= wdata_i[1:0];
      end else if (addr_i == `OFS_LEVEL_A) begin
        level_q[7:0] <= wdata_i;
      end else if (addr_i == `OFS_LEVEL_B) begin
        level_q[15:8] <= wdata_i;
      end else if (addr_i == `OFS_LEVEL_C) begin
        level_q[17:16] <= wdata_i[1:0];
      end else if (addr_i == `OFS_CTRL) begin
        ctrl_q <= {5'h00, wdata_i[2:0]};
      end else if (addr_i == `OFS_IRQ_MASK) begin
        ev_mask_q <= wdata_i[1:0];
      end
    end
  end

  // sticky events: bit0 acknowledge, bit1 break; write one clears, set wins
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_stat_q <= 2'h0;
    end else begin
      ev_stat_q <= (ev_stat_q & ~((wr_i && addr_i == `OFS_IRQ_STAT) ? wdata_i[1:0] : 2'h0))
                   | {ev_brk, ev_ack};
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o             <= 1'b0;
      standby_release_o <= 1'b0;
    end else begin
      irq_o             <= |(ev_stat_q & ev_mask_q);
      standby_release_o <= |(flag_q & ~mask_q);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `OFS_FLAG_A) begin
        rdata_o <= flag_q[7:0];
      end else if (addr_i == `OFS_FLAG_B) begin
        rdata_o <= flag_q[15:8];
      end else if (addr_i == `OFS_FLAG_C) begin
        rdata_o <= {6'h00, flag_q[17:16]};
      end else if (addr_i == `OFS_MASK_A) begin
        rdata_o <= mask_q[7:0];
      end else if (addr_i == `OFS_MASK_B) begin
        rdata_o <= mask_q[15:8];
      end else if (addr_i == `OFS_MASK_C) begin
        rdata_o <= {6'h3f, mask_q[17:16]};
      end else if (addr_i == `OFS_LEVEL_A) begin
        rdata_o <= level_q[7:0];
      end else if (addr_i == `OFS_LEVEL_B) begin
        rdata_o <= level_q[15:8];
      end else if (addr_i == `OFS_LEVEL_C) begin
        rdata_o <= {6'h3f, level_q[17:16]};
      end else if (addr_i == `OFS_CTRL) begin
        rdata_o <= ctrl_q;
      end else if (addr_i == `OFS_STATUS) begin
        rdata_o <= {5'h00, brk_q, svc_q};
      end else if (addr_i == `OFS_IRQ_STAT) begin
        rdata_o <= {6'h00, ev_stat_q};
      end else if (addr_i == `OFS_IRQ_MASK) begin
        rdata_o <= {6'h00, ev_mask_q};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// file: tb/vectored_interrupt_arbiter_assertions.sv
`timescale 1ns/1ns
module vectored_interrupt_arbiter_checker (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // requests and core handshake
  input wire logic        low_voltage_irq_i,
  input wire logic        software_break_instruction_i,
  input wire logic        ack_i,
  input wire logic        int_req_o,
  input wire logic [15:0] vector_o,
  input wire logic        standby_release_o,
  input wire logic        lvd_reset_o
);
  // masks touched since reset; own copy of the detector action bit
  logic mask_wr_q;
  logic lvd_act_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_wr_q <= 1'b0;
      lvd_act_q <= 1'b0;
    end else begin
      if (wr_i && addr_i inside {8'h04, 8'h05, 8'h06}) mask_wr_q <= 1'b1;
      if (wr_i && addr_i == 8'h0c) lvd_act_q <= wdata_i[1];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_ack_drops_offer: assert property (int_req_o && ack_i |=> !int_req_o)
    else $error("offer still up after acknowledge");
  a_offer_holds: assert property (int_req_o && !ack_i |=> int_req_o)
    else $error("offer withdrawn without acknowledge");
  a_break_vector: assert property ($rose(software_break_instruction_i)
    |-> ##[1:8] (int_req_o && vector_o == 16'h003e))
    else $error("break not offered at its vector");
  a_lvd_cause: assert property (lvd_reset_o |-> $past(low_voltage_irq_i))
    else $error("detector reset without detection");
  a_lvd_reset_fires: assert property (low_voltage_irq_i && lvd_act_q |=> lvd_reset_o)
    else $error("detection in reset mode gave no reset");
  a_vector_legal: assert property (int_req_o |-> !vector_o[0] && vector_o inside
    {16'h0004, [16'h0006:16'h0016], [16'h001a:16'h0022], [16'h002a:16'h002e], 16'h003e})
    else $error("offered vector outside the table");
  a_mask_reset: assert property (rd_i && addr_i == 8'h04 && !mask_wr_q |=> rdata_o == 8'hff)
    else $error("mask not all ones after reset");
  a_standby_masked: assert property (!mask_wr_q |-> !standby_release_o)
    else $error("standby release while all sources masked");
  a_lvd_mode_off: assert property (lvd_reset_o |-> $past(lvd_act_q))
    else $error("detector reset with action bit clear");
  c_ack: cover property (int_req_o && ack_i);
  c_break: cover property (int_req_o && vector_o == 16'h003e);
  c_lvd_reset: cover property (lvd_reset_o);
endmodule

bind vectored_interrupt_arbiter vectored_interrupt_arbiter_checker u_chk (
  .mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .low_voltage_irq_i,
  .software_break_instruction_i, .ack_i, .int_req_o, .vector_o, .standby_release_o,
  .lvd_reset_o
);

// file: tb/core_ack_model.sv
`timescale 1ns/1ns
// core side: takes an offered vector after dly_i waiting cycles
module core_ack_model (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // offer from the arbiter
  input  wire logic        int_req_i,
  input  wire logic [15:0] vector_i,
  input  wire logic [3:0]  dly_i,
  // acknowledge and record of what was taken
  output logic             ack_o,
  output logic [15:0]      taken_vec_o,
  output logic [7:0]       taken_cnt_o
);
  logic [3:0] wait_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o       <= 1'b0;
      wait_q      <= 4'h0;
      taken_vec_o <= 16'h0000;
      taken_cnt_o <= 8'h00;
    end else if (int_req_i && ack_o) begin
      ack_o       <= 1'b0;
      wait_q      <= 4'h0;
      taken_vec_o <= vector_i;
      taken_cnt_o <= taken_cnt_o + 8'h01;
    end else if (int_req_i) begin
      wait_q <= wait_q + 4'h1;
      ack_o  <= (wait_q >= dly_i);
    end else begin
      wait_q <= 4'h0;
      ack_o  <= 1'b0;
    end
  end
endmodule

// file: tb/tb_vectored_interrupt_arbiter.sv
`timescale 1ns/1ns
module tb_vectored_interrupt_arbiter;
  logic        mclk_i;
  logic        nrst_i;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        reti;
  logic [3:0]  dly;
  logic [19:0] stim;
  logic [7:0]  rdata;
  logic        int_req;
  logic        ack;
  logic        standby;
  logic        lvd_rst;
  logic        irq;
  logic [15:0] vec;
  logic [15:0] taken_vec;
  logic [7:0]  taken_cnt;
  int          err_total;
  int          tests_run;
  int          seen;

  // stim: [17:0] sources by default order, [18] break, [19] carrier match
  vectored_interrupt_arbiter u_dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .pin_edge_irq_i(stim[6:1]), .key_input_irq_i(stim[17:16]),
    .low_voltage_irq_i(stim[0]), .serial_rx_error_irq_i(stim[7]),
    .serial_rx_done_irq_i(stim[8]), .serial_tx_done_irq_i(stim[9]),
    .high_timer_b_match_irq_i(stim[10]), .high_timer_a_match_irq_i(stim[11]),
    .event_timer_a_match_irq_i(stim[12]), .wide_timer_ch0_irq_i(stim[13]),
    .wide_timer_ch1_irq_i(stim[14]), .event_timer_b_match_irq_i(stim[15]),
    .carrier_match_signal_i(stim[19]), .software_break_instruction_i(stim[18]),
    .ack_i(ack), .reti_i(reti), .int_req_o(int_req), .vector_o(vec),
    .standby_release_o(standby), .lvd_reset_o(lvd_rst), .irq_o(irq));

  core_ack_model u_core (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .int_req_i(int_req), .vector_i(vec), .dly_i(dly),
    .ack_o(ack), .taken_vec_o(taken_vec), .taken_cnt_o(taken_cnt));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic fire(input logic [19:0] m);
    @(posedge mclk_i);
    stim <= m;
    @(posedge mclk_i);
    stim <= '0;
  endtask

  task automatic pop();
    @(posedge mclk_i);
    reti <= 1'b1;
    @(posedge mclk_i);
    reti <= 1'b0;
  endtask

  // waits for the next acknowledge seen by the core model
  task automatic take(input logic [15:0] exp, input bit do_pop);
    int i;
    i = 0;
    // the model counts on the edge; look once it has settled
    #1;
    while (taken_cnt == seen[7:0] && i < 40) begin
      @(posedge mclk_i);
      #1;
      i++;
    end
    seen++;
    chk({8'h00, taken_cnt}, 16'(seen));
    chk(taken_vec, exp);
    if (do_pop) pop();
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge mclk_i);
    #1 chk({8'h00, taken_cnt}, 16'(seen));
  endtask

  function automatic logic [15:0] vec_of(input int i);
    if (i < 7) return 16'h0004 + 16'(2 * i);
    if (i < 10) return 16'h0012 + 16'(2 * (i - 7));
    if (i < 15) return 16'h001a + 16'(2 * (i - 10));
    return 16'h002a + 16'(2 * (i - 15));
  endfunction

  task automatic t_reset_and_break();
    rd8(8'h04, 8'hff);
    rd8(8'h05, 8'hff);
    rd8(8'h06, 8'hff);
    rd8(8'h0a, 8'hff);
    rd8(8'h03, 8'h00);
    fire(20'h40000);
    take(16'h003e, 1'b0);
  endtask

  task automatic t_standby();
    wr8(8'h04, 8'h00);
    wr8(8'h05, 8'h00);
    wr8(8'h06, 8'h00);
    fire(20'h00100);
    quiet(6);
    chk(16'(standby), 16'h0001);
    wr8(8'h0c, 8'h01);
    take(vec_of(8), 1'b1);
  endtask

  task automatic t_vectors();
    for (int i = 0; i < 18; i++) begin
      fire(20'h00001 << i);
      take(vec_of(i), 1'b1);
    end
  endtask

  task automatic t_order();
    dly <= 4'h5;
    fire(20'h01080);
    take(vec_of(7), 1'b1);
    take(vec_of(12), 1'b1);
    fire(20'h00028);
    take(vec_of(3), 1'b1);
    take(vec_of(5), 1'b1);
    dly <= 4'h0;
  endtask

  task automatic t_nest();
    fire(20'h01000);
    take(vec_of(12), 1'b0);
    fire(20'h40000);
    take(16'h003e, 1'b0);
    pop();
    pop();
    wr8(8'h09, 8'hfb);
    fire(20'h01000);
    take(vec_of(12), 1'b0);
    fire(20'h00400);
    take(vec_of(10), 1'b0);
    rd8(8'h0d, 8'h03);
    fire(20'h00800);
    quiet(10);
    pop();
    quiet(4);
    pop();
    take(vec_of(11), 1'b1);
    wr8(8'h09, 8'hff);
  endtask

  task automatic t_mask();
    wr8(8'h04, 8'h04);
    fire(20'h00004);
    quiet(10);
    chk(16'(standby), 16'h0000);
    wr8(8'h04, 8'h00);
    take(vec_of(2), 1'b1);
    rd8(8'h00, 8'h00);
  endtask

  task automatic t_lvd_carrier();
    wr8(8'h0c, 8'h03);
    fire(20'h00001);
    #1 chk(16'(lvd_rst), 16'h0001);
    quiet(10);
    wr8(8'h0c, 8'h05);
    fire(20'h08000);
    quiet(10);
    fire(20'h80000);
    take(16'h002a, 1'b1);
    wr8(8'h0c, 8'h01);
  endtask

  task automatic t_irq();
    wr8(8'h0f, 8'h01);
    repeat (2) @(posedge mclk_i);
    #1 chk(16'(irq), 16'h0001);
    rd8(8'h0e, 8'h03);
    wr8(8'h0e, 8'h03);
    repeat (2) @(posedge mclk_i);
    #1 chk(16'(irq), 16'h0000);
    rd8(8'h0e, 8'h00);
  endtask

  initial begin
    nrst_i    = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    reti      = 1'b0;
    dly       = 4'h0;
    stim      = '0;
    err_total = 0;
    tests_run = 0;
    seen      = 0;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset_and_break();
    t_standby();
    t_vectors();
    t_order();
    t_nest();
    t_mask();
    t_lvd_carrier();
    t_irq();
    end_of_test();
  end

  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
endmodule
